// ---- shared/mff_pkg.sv ----
// Constants, field layout and encodings for the macro fetch unit
package mff_pkg;
  // Microword field layout
  localparam int F_SRC = 0;
  localparam int W_SRC = 2;
  localparam int F_DST = 2;
  localparam int W_DST = 3;
  localparam int F_REG = 5;
  localparam int W_REG = 3;
  localparam int F_OP = 8;
  localparam int W_OP = 2;
  localparam int F_BR = 0;
  localparam int W_BR = 10;
  localparam int F_DPS = 10;
  localparam int W_DPS = 6;
  localparam int F_SEQ = 16;
  localparam int W_SEQ = 4;
  localparam int F_MRD = 20;
  localparam int F_MWR = 21;
  localparam int CS_MAX = 1024;
  localparam int STK_DEPTH = 16;
  // Execute enable bit positions
  localparam int EX_ARITH_REGISTER_SLICE = 0;
  localparam int EX_MAR = 1;
  localparam int EX_IR = 2;
  localparam int EX_STK = 3;
  // Slice register allocation
  localparam logic [2:0] R_AC2 = 3'h2;
  localparam logic [2:0] R_AC3 = 3'h3;
  localparam logic [2:0] R_PC = 3'h4;
  localparam logic [2:0] R_TEMP1 = 3'h5;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CSADDR = 8'h08;
  localparam logic [7:0] A_CSDATA = 8'h0c;
  localparam logic [7:0] A_MAP = 8'h10;
  localparam logic [7:0] A_PANEL = 8'h14;
  localparam logic [7:0] A_PC = 8'h18;
  localparam logic [7:0] A_TEMP1 = 8'h1c;
  localparam logic [7:0] A_MAR = 8'h20;
  localparam logic [7:0] A_EA = 8'h24;
  localparam logic [7:0] A_MASK = 8'hfc;
  localparam int C_RUN = 0;
  localparam int C_START = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {SEQ_ADV = 4'h0, SEQ_BRV0 = 4'h1, SEQ_BRV1 = 4'h2,
    SEQ_BRV2 = 4'h3, SEQ_BRV3 = 4'h4, SEQ_HALT = 4'h5} mff_seq_e;
  typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_ARITH_REGISTER_SLICE = 2'h1, SRC_STACK = 2'h2,
    SRC_IR = 2'h3} mff_src_e;
  typedef enum logic [2:0] {DST_NONE = 3'h0, DST_ARITH_REGISTER_SLICE = 3'h1, DST_MAR = 3'h2,
    DST_IR = 3'h3, DST_STACK = 3'h4} mff_dst_e;
  typedef enum logic [1:0] {ALU_READ = 2'h0, ALU_LOAD = 2'h1, ALU_ADDC = 2'h2,
    ALU_ADD = 2'h3} mff_alu_e;
  typedef enum logic [5:0] {DPS_PASS = 6'h00, DPS_ZERO = 6'h01, DPS_KBUS = 6'h02,
    DPS_KSEXT = 6'h03, DPS_KLOW = 6'h04, DPS_EA = 6'h05} mff_dps_e;
  typedef enum logic [1:0] {MODE_BASE = 2'h0, MODE_PCREL = 2'h1, MODE_AC2REL = 2'h2,
    MODE_AC3REL = 2'h3} mff_mode_e;
endpackage

// ---- rtl/mff_fetch_unit.sv ----
// Microprogrammed macro fetch and decode front end with AXI4-Lite control
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Two-bit index field picks one of four addressing modes.
// - Base page mode uses displacement unmodified, reaching words 0 to 255.
// - Relative modes add signed 8-bit displacement to PC, AC2 or AC3.
// - Slice registers 0-3 accumulators, 4 program counter, 5-7 temporaries.
// - Sixteen-level push/pop stack, all levels usable.
// - Address latch loads from output bus; read data enters via switch input.
// - Memory write data comes straight from the output bus.
// - Instruction latch holds opcode and index bits.
// - Sequencer is pipelined through a microinstruction register.
// - While inhibit is active, source, destination, slice fields form branch address.
// - Microword has six-bit switch field and four-bit sequencer field.
// - Source decodes to one output drive enable, destination to execute enable.
// - Latches load on the single system clock, each enabled by destination decode.
// - Branch address comes from four-way mux steered by sequencer via select.
// - Mapper turns instruction latch into routine start address.
// - Fetch step one reads register four into slice output register.
// - Step two moves PC to address latch and starts memory read.
// - Step three increments register four by add with carry, zero inputs.
// - Step four loads upper memory byte into instruction latch.
// - Step five loads sign-extended low byte into register five.
// - Steps one to five advance sequentially.
// - Step six branches via source one to mapper output.
module mff_fetch_unit
  import mff_pkg::*;
#(
  parameter int CS_DEPTH = 1024
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Main memory
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  // Decode visibility
  output logic [3:0] OUT_DRIVE_EN_N,
  output logic [3:0] EXEC_EN_N,
  output logic FIELD_SHARE_INH
);
  localparam int AW = $clog2(CS_DEPTH);

  if (CS_DEPTH < 8 || CS_DEPTH > CS_MAX || (CS_DEPTH & (CS_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("CS_DEPTH must be a power of two from 8 to 1024");
  end

  typedef struct packed {
    logic [CS_DEPTH-1:0][31:0] cs;
    logic [31:0] mir;
    logic [9:0] upc;
    logic run;
    logic [7:0][15:0] r;
    logic [15:0] aout;
    logic [15:0] memory_address_latch;
    logic [7:0] ir;
    logic [STK_DEPTH-1:0][15:0] stk;
    logic [4:0] sp;
    logic [9:0] cs_ptr;
    logic [3:0] map_base;
    logic [9:0] panel;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } mff_state_s;

  mff_state_s q;
  mff_state_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Microword decode

  logic [31:0] mw;
  mff_seq_e seq;
  logic field_share_inhibit;
  mff_src_e src;
  mff_dst_e dst;
  mff_alu_e op;
  logic [2:0] rsel;
  mff_dps_e data_path_switch;
  logic [1:0] via;
  logic axw;
  logic [3:0] oe_n;
  logic [3:0] ex_n;

  assign mw = q.mir;
  assign seq = mff_seq_e'(mw[F_SEQ +: W_SEQ]);
  // Branch opcodes borrow the data path fields
  assign field_share_inhibit = q.run && seq >= SEQ_BRV0 && seq <= SEQ_BRV3;
  assign src = (field_share_inhibit || !q.run) ? SRC_NONE : mff_src_e'(mw[F_SRC +: W_SRC]);
  assign dst = (field_share_inhibit || !q.run) ? DST_NONE : mff_dst_e'(mw[F_DST +: W_DST]);
  assign op = mff_alu_e'(mw[F_OP +: W_OP]);
  assign rsel = mw[F_REG +: W_REG];
  assign data_path_switch = mff_dps_e'(mw[F_DPS +: W_DPS]);
  assign via = 2'(mw[F_SEQ +: 2] - 2'h1);
  assign axw = q.aw_ok && q.w_ok;
  assign oe_n = ~(4'h1 << src);
  // Single clock: latch "gating" is a clock enable per destination
  assign ex_n = (dst == DST_NONE) ? 4'hf : ~(4'h1 << (dst - DST_ARITH_REGISTER_SLICE));

  ////////////////////////////////////////////////////////////////////////////
  // Data path: buses, switch array, addressing modes

  logic [15:0] d_bus;
  logic [15:0] o_bus;
  logic [15:0] stk_top;
  logic [15:0] disp;
  logic [15:0] base;
  logic [15:0] ea;
  logic [15:0] rv;
  logic [15:0] sum;
  mff_mode_e mode;

  assign stk_top = (q.sp == 5'h00) ? 16'h0000 : q.stk[4'(q.sp - 5'h01)];
  assign mode = mff_mode_e'(q.ir[1:0]);
  assign disp = q.r[R_TEMP1];

  always_comb
  begin
    case (src)
      SRC_ARITH_REGISTER_SLICE: d_bus = q.aout;
      SRC_STACK: d_bus = stk_top;
      SRC_IR: d_bus = {8'h00, q.ir};
      default: d_bus = 16'h0000;
    endcase
    case (mode)
      MODE_PCREL: base = q.r[R_PC];
      MODE_AC2REL: base = q.r[R_AC2];
      MODE_AC3REL: base = q.r[R_AC3];
      default: base = 16'h0000;
    endcase
    if (mode == MODE_BASE)
      ea = {8'h00, disp[7:0]};
    else
      ea = base + disp;
    case (data_path_switch)
      DPS_PASS: o_bus = d_bus;
      DPS_KBUS: o_bus = MEM_RDATA;
      DPS_KSEXT: o_bus = {{8{MEM_RDATA[7]}}, MEM_RDATA[7:0]};
      DPS_KLOW: o_bus = {8'h00, MEM_RDATA[7:0]};
      DPS_EA: o_bus = ea;
      default: o_bus = 16'h0000;
    endcase
  end

  assign rv = q.r[rsel];
  assign sum = rv + o_bus + {15'h0000, op == ALU_ADDC};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next address

  logic [9:0] mapper;
  logic [3:0][9:0] bsel;
  logic [9:0] nxt;

  assign mapper = {q.map_base, q.ir[7:2]};
  assign bsel = {10'h000, q.panel, mapper, mw[F_BR +: W_BR]};

  always_comb
  begin
    case (seq)
      SEQ_ADV: nxt = 10'(q.upc + 10'h001);
      SEQ_BRV0, SEQ_BRV1, SEQ_BRV2, SEQ_BRV3: nxt = bsel[via];
      SEQ_HALT: nxt = q.upc;
      default: nxt = 10'(q.upc + 10'h001);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [32:0] regval(input logic [7:0] a, input mff_state_s s,
    input logic [15:0] eav);
    logic [32:0] v;
    v = {1'b1, 32'h00000000};
    case (a & A_MASK)
      A_CTRL: v[31:0] = {6'h00, s.upc, 15'h0000, s.run};
      A_STATUS: v[31:0] = {11'h000, s.sp, 8'h00, s.ir};
      A_CSADDR: v[31:0] = {22'h000000, s.cs_ptr};
      A_CSDATA: v[31:0] = s.cs[s.cs_ptr[AW-1:0]];
      A_MAP: v[31:0] = {28'h0000000, s.map_base};
      A_PANEL: v[31:0] = {22'h000000, s.panel};
      A_PC: v[31:0] = {16'h0000, s.r[R_PC]};
      A_TEMP1: v[31:0] = {16'h0000, s.r[R_TEMP1]};
      A_MAR: v[31:0] = {16'h0000, s.memory_address_latch};
      A_EA: v[31:0] = {16'h0000, eav};
      default: v[32] = 1'b0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [32:0] wcur;
  logic [31:0] wm;

  assign wcur = regval(q.awa, q, ea);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wm[i*8 +: 8] = q.ws[i] ? q.wd[i*8 +: 8] : wcur[i*8 +: 8];
  end

  always_comb
  begin
    logic [4:0] sp2;
    logic [32:0] rdv;
    sp2 = q.sp;
    rdv = regval(S_AXI_ARADDR, q, ea);
    d = q;
    // Pipelined sequencer: fetch next word while current executes
    if (q.run)
    begin
      d.upc = nxt;
      d.mir = q.cs[nxt[AW-1:0]];
      if (seq == SEQ_HALT)
        d.run = 1'b0;
    end
    if (!ex_n[EX_ARITH_REGISTER_SLICE])
    begin
      case (op)
        ALU_READ: d.aout = rv;
        ALU_LOAD:
        begin
          d.r[rsel] = o_bus;
          d.aout = o_bus;
        end
        default:
        begin
          d.r[rsel] = sum;
          d.aout = sum;
        end
      endcase
    end
    if (!ex_n[EX_MAR])
      d.memory_address_latch = d_bus;
    if (!ex_n[EX_IR])
      d.ir = MEM_RDATA[15:8];
    // Pop then push in one cycle replaces the top word
    if (src == SRC_STACK && sp2 != 5'h00)
      sp2 = 5'(sp2 - 5'h01);
    if (!ex_n[EX_STK] && sp2 < 5'(STK_DEPTH))
    begin
      d.stk[sp2[3:0]] = o_bus;
      sp2 = 5'(sp2 + 5'h01);
    end
    d.sp = sp2;
    // AXI write channels are taken independently
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      d.aw_ok = 1'b1;
      d.awa = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      d.w_ok = 1'b1;
      d.wd = S_AXI_WDATA;
      d.ws = S_AXI_WSTRB;
    end
    if (axw)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bv = 1'b1;
      d.br = wcur[32] ? RESP_OKAY : RESP_SLVERR;
      case (q.awa & A_MASK)
        A_CTRL:
        begin
          // Start only on a rising run bit, so rewrites do not restart
          if (wm[C_RUN] && !q.run)
          begin
            d.upc = wm[C_START +: W_BR];
            d.mir = q.cs[wm[C_START +: AW]];
          end
          d.run = wm[C_RUN];
        end
        A_CSADDR: d.cs_ptr = wm[W_BR-1:0];
        A_CSDATA:
        begin
          d.cs[q.cs_ptr[AW-1:0]] = wm;
          d.cs_ptr = 10'(q.cs_ptr + 10'h001);
        end
        A_MAP: d.map_base = wm[3:0];
        A_PANEL: d.panel = wm[W_BR-1:0];
        A_PC: d.r[R_PC] = wm[15:0];
        A_TEMP1: d.r[R_TEMP1] = wm[15:0];
        A_MAR: d.memory_address_latch = wm[15:0];
        default: d.br = d.br;
      endcase
    end
    else if (q.bv && S_AXI_BREADY)
      d.bv = 1'b0;
    if (S_AXI_ARVALID && !q.rv)
    begin
      d.rv = 1'b1;
      d.rd = rdv[31:0];
      d.rr = rdv[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (q.rv && S_AXI_RREADY)
      d.rv = 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      q <= '0;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign S_AXI_AWREADY = !q.aw_ok && !q.bv;
  assign S_AXI_WREADY = !q.w_ok && !q.bv;
  assign S_AXI_BVALID = q.bv;
  assign S_AXI_BRESP = q.br;
  assign S_AXI_ARREADY = !q.rv;
  assign S_AXI_RVALID = q.rv;
  assign S_AXI_RDATA = q.rd;
  assign S_AXI_RRESP = q.rr;
  assign MEM_ADDR = q.memory_address_latch;
  assign MEM_RD = q.run && !field_share_inhibit && mw[F_MRD];
  assign MEM_WR = q.run && !field_share_inhibit && mw[F_MWR];
  // No write data register: memory sees the bus directly
  assign MEM_WDATA = d_bus;
  assign OUT_DRIVE_EN_N = oe_n;
  assign EXEC_EN_N = ex_n;
  assign FIELD_SHARE_INH = field_share_inhibit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  sequence s_mar_load;
    !ex_n[EX_MAR];
  endsequence
  sequence s_pc_incr;
    !ex_n[EX_ARITH_REGISTER_SLICE] && op == ALU_ADDC && rsel == R_PC && data_path_switch == DPS_ZERO;
  endsequence
  sequence s_sext_load;
    !ex_n[EX_ARITH_REGISTER_SLICE] && op == ALU_LOAD && rsel == R_TEMP1 && data_path_switch == DPS_KSEXT;
  endsequence

  chk_oe_onehot: assert property ($onehot(~oe_n) && $onehot0(~ex_n))
    else $error("drive or execute enables not one-hot");
  chk_mar_latch: assert property (s_mar_load |=> q.memory_address_latch == $past(d_bus))
    else $error("address latch missed the bus");
  chk_ir_latch: assert property (!ex_n[EX_IR] |=> q.ir == $past(MEM_RDATA[15:8]))
    else $error("instruction latch missed upper byte");
  chk_seq_adv: assert property (q.run && seq == SEQ_ADV && !axw
    |=> q.upc == 10'($past(q.upc) + 10'h001))
    else $error("sequential advance wrong");
  chk_brv1_map: assert property (q.run && seq == SEQ_BRV1 && !axw
    |=> q.upc == $past(mapper) && q.mir == $past(q.cs[mapper[AW-1:0]]))
    else $error("branch via source one missed mapper");
  chk_inh_quiet: assert property (field_share_inhibit |-> EXEC_EN_N == 4'hf && !MEM_RD)
    else $error("data path active during field share");
  chk_pc_incr: assert property (s_pc_incr
    |=> q.r[R_PC] == 16'($past(q.r[R_PC]) + 16'h0001))
    else $error("program counter not incremented");
  chk_sext_load: assert property (s_sext_load
    |=> q.r[R_TEMP1] == {{8{$past(MEM_RDATA[7])}}, $past(MEM_RDATA[7:0])})
    else $error("displacement not sign extended");
  chk_base_page: assert property (mode == MODE_BASE |-> ea[15:8] == 8'h00)
    else $error("base page address above 255");
  chk_stack_push: assert property (!ex_n[EX_STK] && src != SRC_STACK && q.sp < 5'h10
    |=> q.sp == 5'($past(q.sp) + 5'h01))
    else $error("stack push lost");
  chk_axi_bhold: assert property (q.bv && !S_AXI_BREADY |=> q.bv && $stable(q.br))
    else $error("write response dropped early");
endmodule

// ---- sim/mff_mem_model.sv ----
// Main memory partner model for the macro fetch unit
`timescale 1ns/1ps
module mff_mem_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Memory side
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic slow,
  output logic [15:0] rdata
);
  logic [15:0] mem [256];
  logic [2:0] age;
  logic [15:0] last;
  logic live;
  ////////////////////////////////////////////////////////////////////////////////
  // Slow answers only from the second cycle; stale data shows inverted
  assign live = (age == 3'h2) || (age == 3'h3) || ((age == 3'h1) && !slow);
  assign rdata = live ? mem[addr[7:0]] : ~last;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      age <= 3'h0;
    else if (rd)
      age <= 3'h1;
    else if (age != 3'h0 && age < 3'h4)
      age <= age + 3'h1;
    else
      age <= 3'h0;
    if (live)
      last <= mem[addr[7:0]];
  end
  // Plain always: the bench preloads words from outside
  always @(posedge clk)
  begin
    if (wr)
      mem[addr[7:0]] <= wdata;
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench for the macro fetch unit
`timescale 1ns/1ps
module tb_top
  import mff_pkg::*;
;
  typedef struct {logic [15:0] pc; logic [15:0] ins; logic slow;} mff_row_s;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic slow = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr, field_share_inhibit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, exp_pc;
  logic [3:0] eo_n, ex_n;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int rd_cnt = 0;
  int inh_cnt = 0;
  // Fetch routine, then a halt word placed at each mapped target
  logic [31:0] fetch [6] = '{32'h84, 32'h100009, 32'h684, 32'hc, 32'hda4, 32'h20000};
  mff_row_s rows [4] = '{'{16'h0010, 16'h04f0, 1'b0}, '{16'h0020, 16'h0d80, 1'b0},
    '{16'h0030, 16'h127f, 1'b1}, '{16'h00ff, 16'h1f01, 1'b1}};
  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  mff_fetch_unit mff_fetch_unit_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .OUT_DRIVE_EN_N(eo_n),
    .EXEC_EN_N(ex_n), .FIELD_SHARE_INH(field_share_inhibit));
  mff_mem_model mff_mem_model_inst (.clk(clk_sys), .rst_n(reset_n), .addr(mem_addr),
    .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata), .slow(slow), .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Both channels offered together; each released on its own handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw, got;
    da = 1'b0;
    dw = 1'b0;
    got = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk_sys);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    while (!got)
    begin
      @(negedge clk_sys);
      got = bvalid;
      r = bresp;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(negedge clk_sys);
      got = arready;
      @(posedge clk_sys);
    end
    arvalid <= 1'b0;
    got = 1'b0;
    while (!got)
    begin
      @(negedge clk_sys);
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
    end
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    cmp_word(d & m, e);
  endtask
  // Accumulators stay zero, so their modes see the displacement alone
  function automatic logic [15:0] ea_of(input mff_row_s w);
    logic [15:0] sx;
    sx = {{8{w.ins[7]}}, w.ins[7:0]};
    case (w.ins[9:8])
      2'h0: return {8'h00, w.ins[7:0]};
      2'h1: return w.pc + 16'h1 + sx;
      default: return sx;
    endcase
  endfunction
  task automatic run_row(input mff_row_s w);
    logic [31:0] d;
    logic [1:0] r;
    mff_mem_model_inst.mem[w.pc[7:0]] = w.ins;
    slow <= w.slow;
    wr(A_CSADDR, {22'h0, 4'h1, w.ins[15:10]});
    wr(A_CSDATA, 32'h50000);
    wr(A_PC, {16'h0, w.pc});
    exp_pc = w.pc;
    rd_cnt = 0;
    inh_cnt = 0;
    wr(A_CTRL, 32'h1);
    d = 32'h1;
    // A wrong mapper target never halts and runs into the timeout
    while (d[0] !== 1'b0)
      axi_read(A_CTRL, d, r);
    chk_reg(A_STATUS, 32'hff, {24'h0, w.ins[15:8]});
    chk_reg(A_PC, 32'hffff, {16'h0, w.pc + 16'h1});
    chk_reg(A_TEMP1, 32'hffff, {16'h0, {8{w.ins[7]}}, w.ins[7:0]});
    chk_reg(A_EA, 32'hffff, {16'h0, ea_of(w)});
    chk_reg(A_MAR, 32'hffff, {16'h0, w.pc});
    cmp_word({16'h0, mem_addr}, {16'h0, w.pc});
    cmp_word(rd_cnt, 1);
    cmp_word(inh_cnt, 1);
    $display("test fetch pc %h done", w.pc);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys)
  begin
    if (reset_n && mem_rd)
    begin
      rd_cnt++;
      cmp_word({16'h0, mem_wdata}, {16'h0, exp_pc});
      cmp_word(eo_n, 4'hd);
      cmp_word(ex_n, 4'hd);
      cmp_word(mem_wr, 1'b0);
    end
    if (reset_n && field_share_inhibit)
      inh_cnt++;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      close_out;
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    cmp_word(eo_n, 4'he);
    cmp_word(ex_n, 4'hf);
    chk_reg(A_CTRL, 32'hffffffff, 32'h0);
    axi_read(8'h28, d, r);
    cmp_resp(r, RESP_SLVERR);
    cmp_word(d, 32'h0);
    axi_write(A_EA, 32'h1234, r);
    cmp_resp(r, RESP_OKAY);
    $display("test reset and bus done");
    wr(A_CSADDR, 32'h0);
    foreach (fetch[i])
      wr(A_CSDATA, fetch[i]);
    wr(A_MAP, 32'h1);
    foreach (rows[i])
      run_row(rows[i]);
    // Two pushes then a pop into the program counter
    wr(A_CSADDR, 32'h10);
    wr(A_CSDATA, 32'h1410);
    wr(A_CSDATA, 32'h1410);
    wr(A_CSDATA, 32'h186);
    wr(A_CSDATA, 32'h50000);
    wr(A_CTRL, 32'h00100001);
    d = 32'h1;
    while (d[0] !== 1'b0)
      axi_read(A_CTRL, d, r);
    chk_reg(A_STATUS, 32'h1f0000, 32'h10000);
    chk_reg(A_PC, 32'hffff, {16'h0, ea_of(rows[3])});
    $display("test stack done");
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk_reg(A_PC, 32'hffff, 32'h0);
    chk_reg(A_CTRL, 32'hffffffff, 32'h0);
    $display("test second reset done");
    close_out;
  end
endmodule
